// File: core/smcr_defs.vh
`ifndef SMCR_DEFS_VH
`define SMCR_DEFS_VH

// ----------------------------------------
// Register index map
// ----------------------------------------
`define SMCR_IDX_MODE_CFG     8'h08
`define SMCR_IDX_PAUSE        8'h09
`define SMCR_IDX_EDGES        8'h0A
`define SMCR_IDX_OPTION       8'h0B
`define SMCR_IDX_RW_MEAS      8'h02
`define SMCR_IDX_RW_CFG       8'h00

// ----------------------------------------
// Field positions of the mode config and option registers
// ----------------------------------------
`define SMCR_MODE_HI          7
`define SMCR_MODE_LO          6
`define SMCR_HOLD_BIT         4
`define SMCR_DRIVE_BIT        3
`define SMCR_CORE_CLOCK_SEL_HI          1
`define SMCR_CORE_CLOCK_SEL_LO          0
`define SMCR_REWIND_BIT       0

// ----------------------------------------
// Measurement modes
// ----------------------------------------
`define SMCR_MODE_FREE        2'h0
`define SMCR_MODE_CMD         2'h1
`define SMCR_MODE_EXT         2'h2
`define SMCR_MODE_EXT_SS      2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMCR_RST_MODE         2'h1
`define SMCR_RST_HOLD         1'b0
`define SMCR_RST_DRIVE        1'b0
`define SMCR_RST_CORE_CLOCK_SEL         2'h0
`define SMCR_RST_PAUSE        8'h19
`define SMCR_RST_EDGES        8'h01
`define SMCR_RST_OPT_RSV      7'h39
`define SMCR_RST_REWIND       1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMCR_SYS_MHZ          100
`define SMCR_WAKE_US          4
`define SMCR_WAKE_CYC         (`SMCR_WAKE_US * `SMCR_SYS_MHZ)
`define SMCR_PAUSE_STEP_US    8
`define SMCR_PAUSE_STEP_CYC   (`SMCR_PAUSE_STEP_US * `SMCR_SYS_MHZ)
`define SMCR_PAUSE_MIN_TICKS  2'h3
// Phase increment for 1.024 MHz out of 100 MHz on a 32-bit accumulator
`define SMCR_PHASE_INC_BASE   32'h029F_16B1

`endif

// File: core/smcr_regs.v
// Contract
// - Mode field selects free, command, sync modes
// - Mode field resets to command mode
// - Standby bit holds core in low power
// - Ready to resume 4 us after standby
// - Ready pin push-pull or open-drain by bit
// - Ready pin driven low while measuring
// - Clock select sets internal tick rate
// - Reserved config bits reset and read zero
// - Pause of value times 8 us between measurements
// - Pause register resets to 19h
// - Zero pause still gives three core ticks
// - Sync-ended mode counts falling edges to end
// - Edge count zero is stored as one
// - Rewind off keeps index across STOP
// - Rewind on resets index on STOP
// - Index increments after every data byte
// - Written index used for repeated-start read
// - Option reserved bits reset to 0111001
// - Measuring flag is inverse of ready level
`timescale 1ns/10ps
`include "smcr_defs.vh"

module smcr_regs #(
    parameter [17:0] PAUSE_STEP_CYC = `SMCR_PAUSE_STEP_CYC
) (
    // Clock and reset
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        sw_reset_in,
    // Byte transfers from the serial engine
    input  wire        idx_wr_in,
    input  wire        data_wr_in,
    input  wire        data_rd_in,
    input  wire [7:0]  wdata_in,
    input  wire        stop_in,
    input  wire        meas_state_in,
    output wire [7:0]  rdata_out,
    output wire [7:0]  index_out,
    // Measurement control
    input  wire        cmd_start_in,
    input  wire        sync_input_in,
    input  wire [23:0] conv_ticks_in,
    // Ready pin and status
    output wire        ready_pin_out,
    output wire        ready_pin_oe_out,
    output wire        measuring_flag_out,
    output wire        hold_active_out,
    output wire        core_tick_out
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;  // Waiting for a start
    localparam [1:0] ST_CONV  = 2'h1;  // Conversion running
    localparam [1:0] ST_PAUSE = 2'h2;  // Pause between measurements
    // Wake count cut to the counter width on purpose; 400 fits in nine bits
    localparam integer WAKE_CYC_FULL = `SMCR_WAKE_CYC;
    localparam [8:0]   WAKE_CYC      = WAKE_CYC_FULL[8:0];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Configuration fields are kept apart; reads put them back together
    reg [1:0]  mode_reg;          // Measurement mode select
    reg        hold_reg;          // Low power hold request
    reg        drive_reg;         // Ready pin drive select
    reg [1:0]  core_clock_sel_reg;          // Core clock select
    reg [7:0]  pause_reg;         // Pause interval in 8 us steps
    reg [7:0]  edges_reg;         // Edge count for sync-ended mode
    reg [6:0]  opt_rsv_reg;       // Reserved option bits
    reg        rewind_reg;        // Pointer auto rewind
    reg [7:0]  idx_reg;           // Register index pointer
    reg [7:0]  rdata_reg;         // Read data byte
    reg [31:0] phase_reg;         // Core tick phase accumulator
    reg        tick_reg;          // One-cycle core tick
    reg [8:0]  wake_reg;          // Wake-up countdown
    reg [1:0]  state_reg;         // Measurement state
    reg [23:0] conv_cnt_reg;      // Conversion tick / edge counter
    reg [17:0] step_cnt_reg;      // Cycles within one pause step
    reg [7:0]  pause_cnt_reg;     // Pause steps done
    reg [1:0]  min_cnt_reg;       // Minimum pause ticks
    reg        sync_prev_reg;     // Previous sync level

    // ----------------------------------------
    // Combinational helpers
    // ----------------------------------------
    // Plain decodes of the registers; no state is kept here
    wire        sync_fall   = sync_prev_reg & ~sync_input_in;
    wire        awake       = ~hold_reg & (wake_reg == 9'h000);
    wire [31:0] phase_inc   = `SMCR_PHASE_INC_BASE << core_clock_sel_reg;
    wire [32:0] phase_sum   = {1'b0, phase_reg} + {1'b0, phase_inc};
    wire        meas_active = (state_reg == ST_CONV);
    wire        pause_done;
    wire        reg_wr_en   = data_wr_in;

    // Zero pause uses three core ticks, otherwise whole 8 us steps
    assign pause_done = (pause_reg == 8'h00) ?
                        (min_cnt_reg == `SMCR_PAUSE_MIN_TICKS) :
                        (pause_cnt_reg == pause_reg);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Both resets load defaults; reserved config bits are not stored
    // Indices outside this bank are ignored here but still step the index
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mode_reg    <= `SMCR_RST_MODE;
            hold_reg    <= `SMCR_RST_HOLD;
            drive_reg   <= `SMCR_RST_DRIVE;
            core_clock_sel_reg    <= `SMCR_RST_CORE_CLOCK_SEL;
            pause_reg   <= `SMCR_RST_PAUSE;
            edges_reg   <= `SMCR_RST_EDGES;
            opt_rsv_reg <= `SMCR_RST_OPT_RSV;
            rewind_reg  <= `SMCR_RST_REWIND;
        end else if (sw_reset_in) begin
            mode_reg    <= `SMCR_RST_MODE;
            hold_reg    <= `SMCR_RST_HOLD;
            drive_reg   <= `SMCR_RST_DRIVE;
            core_clock_sel_reg    <= `SMCR_RST_CORE_CLOCK_SEL;
            pause_reg   <= `SMCR_RST_PAUSE;
            edges_reg   <= `SMCR_RST_EDGES;
            opt_rsv_reg <= `SMCR_RST_OPT_RSV;
            rewind_reg  <= `SMCR_RST_REWIND;
        end else if (reg_wr_en) begin
            case (idx_reg)
                `SMCR_IDX_MODE_CFG: begin
                    mode_reg  <= wdata_in[`SMCR_MODE_HI:`SMCR_MODE_LO];
                    hold_reg  <= wdata_in[`SMCR_HOLD_BIT];
                    drive_reg <= wdata_in[`SMCR_DRIVE_BIT];
                    core_clock_sel_reg  <= wdata_in[`SMCR_CORE_CLOCK_SEL_HI:`SMCR_CORE_CLOCK_SEL_LO];
                end
                `SMCR_IDX_PAUSE: begin
                    pause_reg <= wdata_in;
                end
                `SMCR_IDX_EDGES: begin
                    // A forbidden zero falls back to one
                    edges_reg <= (wdata_in == 8'h00) ? `SMCR_RST_EDGES : wdata_in;
                end
                `SMCR_IDX_OPTION: begin
                    opt_rsv_reg <= wdata_in[7:1];
                    rewind_reg  <= wdata_in[`SMCR_REWIND_BIT];
                end
                default: begin
                    // Other indices belong to other banks
                    mode_reg <= mode_reg;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Index pointer
    // ----------------------------------------
    // Data bytes step the index; STOP rewinds only when enabled
    // An index write wins over a data byte in the same cycle
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            idx_reg <= 8'h00;
        end else if (idx_wr_in) begin
            // Index write; a repeated-start read then begins here
            idx_reg <= wdata_in;
        end else if (data_wr_in | data_rd_in) begin
            idx_reg <= idx_reg + 8'h01;
        end else if (stop_in & rewind_reg) begin
            // Default start depends on operating state
            idx_reg <= meas_state_in ? `SMCR_IDX_RW_MEAS : `SMCR_IDX_RW_CFG;
        end else begin
            // Without rewind the index survives STOP
            idx_reg <= idx_reg;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Registered so the byte is stable while it is shifted out
    // Valid one cycle after the index moves
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 8'h00;
        end else begin
            case (idx_reg)
                `SMCR_IDX_MODE_CFG: begin
                    // Reserved bits 5 and 2 read zero
                    rdata_reg <= {mode_reg, 1'b0, hold_reg, drive_reg, 1'b0, core_clock_sel_reg};
                end
                `SMCR_IDX_PAUSE: begin
                    rdata_reg <= pause_reg;
                end
                `SMCR_IDX_EDGES: begin
                    rdata_reg <= edges_reg;
                end
                `SMCR_IDX_OPTION: begin
                    rdata_reg <= {opt_rsv_reg, rewind_reg};
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Core tick generator
    // ----------------------------------------
    // Fractional accumulator; ticks jitter by one cycle but average exactly
    // Each step of the select doubles the increment and so the tick rate
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_reg <= 32'h0000_0000;
            tick_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_sum[31:0];
            tick_reg  <= phase_sum[32];
        end
    end

    // ----------------------------------------
    // Standby and wake-up
    // ----------------------------------------
    // Held at the full count during hold, counts down once released
    // Starts stay blocked until the count runs out
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wake_reg <= 9'h000;
        end else if (hold_reg) begin
            wake_reg <= WAKE_CYC;
        end else if (wake_reg != 9'h000) begin
            wake_reg <= wake_reg - 9'h001;
        end else begin
            wake_reg <= 9'h000;
        end
    end

    // ----------------------------------------
    // Sync edge detect
    // ----------------------------------------
    // A fall is a high sample followed by a low one
    // Clears low, so a line that idles high gives no false fall after reset
    // The pin is taken as synchronous; a free-running source needs a synchroniser ahead
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync_prev_reg <= 1'b0;
        end else begin
            sync_prev_reg <= sync_input_in;
        end
    end

    // ----------------------------------------
    // Measurement sequencer
    // ----------------------------------------
    // Hold aborts any measurement; a new one waits for the wake time
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg     <= ST_IDLE;
            conv_cnt_reg  <= 24'h00_0000;
            step_cnt_reg  <= 18'h0_0000;
            pause_cnt_reg <= 8'h00;
            min_cnt_reg   <= 2'h0;
        end else if (~awake | sw_reset_in) begin
            state_reg     <= ST_IDLE;
            conv_cnt_reg  <= 24'h00_0000;
            step_cnt_reg  <= 18'h0_0000;
            pause_cnt_reg <= 8'h00;
            min_cnt_reg   <= 2'h0;
        end else begin
            case (state_reg)
                // Idle: wait for the start condition of the mode
                ST_IDLE: begin
                    conv_cnt_reg <= 24'h00_0000;
                    // Start condition per mode
                    if ((mode_reg == `SMCR_MODE_FREE) ||
                        ((mode_reg == `SMCR_MODE_CMD) && cmd_start_in) ||
                        ((mode_reg[1]) && sync_fall)) begin
                        state_reg <= ST_CONV;
                    end
                end
                // Conversion: ended by sync edges or by core ticks
                ST_CONV: begin
                    if (mode_reg == `SMCR_MODE_EXT_SS) begin
                        // End after the set number of further falling edges
                        if (sync_fall) begin
                            if (conv_cnt_reg[7:0] + 8'h01 >= edges_reg) begin
                                state_reg <= ST_PAUSE;
                            end
                            conv_cnt_reg <= conv_cnt_reg + 24'h00_0001;
                        end
                    // Other modes run for the given number of core ticks
                    end else if (tick_reg) begin
                        if (conv_cnt_reg + 24'h00_0001 >= conv_ticks_in) begin
                            // Command mode skips the pause
                            state_reg <= (mode_reg == `SMCR_MODE_CMD) ? ST_IDLE : ST_PAUSE;
                        end
                        conv_cnt_reg <= conv_cnt_reg + 24'h00_0001;
                    end
                    step_cnt_reg  <= 18'h0_0000;
                    pause_cnt_reg <= 8'h00;
                    min_cnt_reg   <= 2'h0;
                end
                // Pause: sync edges seen here are ignored
                ST_PAUSE: begin
                    if (pause_done) begin
                        // Free running restarts at once, sync modes wait for an edge
                        state_reg <= (mode_reg == `SMCR_MODE_FREE) ? ST_CONV : ST_IDLE;
                        conv_cnt_reg <= 24'h00_0000;
                    end
                    // Step counter divides the system clock into pause steps
                    if (step_cnt_reg == PAUSE_STEP_CYC - 18'h0_0001) begin
                        step_cnt_reg  <= 18'h0_0000;
                        pause_cnt_reg <= pause_cnt_reg + 8'h01;
                    end else begin
                        step_cnt_reg <= step_cnt_reg + 18'h0_0001;
                    end
                    // Core ticks counted in parallel for the zero setting
                    if (tick_reg && (min_cnt_reg != `SMCR_PAUSE_MIN_TICKS)) begin
                        min_cnt_reg <= min_cnt_reg + 2'h1;
                    end
                end
                // Unused code falls back to idle
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Push-pull drives the inverse of measuring; open-drain only pulls low
    // Open-drain lets several parts share one pulled-up line
    assign ready_pin_out      = drive_reg ? 1'b0 : ~meas_active;
    assign ready_pin_oe_out   = drive_reg ? meas_active : 1'b1;
    assign measuring_flag_out = meas_active;
    assign hold_active_out    = hold_reg;
    assign core_tick_out      = tick_reg;
    assign rdata_out          = rdata_reg;
    assign index_out          = idx_reg;

endmodule

// File: testbench/smcr_regs_monitor.sv
`timescale 1ns/10ps
module smcr_regs_monitor (
    // Clock and reset
    input wire       clk_sys_in,
    input wire       rst_in,
    // Byte side
    input wire       idx_wr_in,
    input wire       data_wr_in,
    input wire       data_rd_in,
    input wire [7:0] wdata_in,
    input wire       stop_in,
    input wire       meas_state_in,
    input wire [7:0] rdata_out,
    input wire [7:0] index_out,
    // Pin and status
    input wire       ready_pin_out,
    input wire       ready_pin_oe_out,
    input wire       measuring_flag_out,
    input wire       hold_active_out,
    input wire       core_tick_out
);
    // ----------------------------------------
    // Cycles since the hold bit last dropped
    // ----------------------------------------
    reg [9:0] wake_cnt; // Saturates so long runs never wrap
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wake_cnt <= 10'h3E8;
        end else if (hold_active_out) begin
            wake_cnt <= 10'h000;
        end else if (wake_cnt != 10'h3E8) begin
            wake_cnt <= wake_cnt + 10'h001;
        end
    end
    default clocking mon_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ready_low: assert property (measuring_flag_out |-> !ready_pin_out)
        else $error("ready pin high while measuring");
    chk_flag_inverse: assert property (measuring_flag_out ==
        !(ready_pin_oe_out ? ready_pin_out : 1'b1)) else $error("flag not inverse of pin");
    chk_index_load: assert property (idx_wr_in |=> index_out == $past(wdata_in))
        else $error("index not loaded");
    chk_index_step: assert property ((data_wr_in || data_rd_in) && !idx_wr_in
        |=> index_out == $past(index_out) + 8'h01) else $error("index not stepped");
    chk_stop_index: assert property (stop_in && !idx_wr_in && !data_wr_in && !data_rd_in
        |=> (index_out == $past(index_out)) || (index_out == ($past(meas_state_in) ?
        8'h02 : 8'h00))) else $error("index wrong after stop");
    chk_hold_abort: assert property (hold_active_out |=> !measuring_flag_out)
        else $error("measuring during hold");
    chk_wake_gap: assert property ($rose(measuring_flag_out) |-> wake_cnt >= 10'h18F)
        else $error("start too soon after hold");
    chk_tick_pulse: assert property (core_tick_out |=> !core_tick_out [*5])
        else $error("core tick too close");
    chk_cfg_reserved: assert property (index_out == 8'h08 && $stable(index_out)
        |-> rdata_out[5] == 1'b0 && rdata_out[2] == 1'b0) else $error("reserved bit set");
    chk_reset_idle: assert property ($fell(rst_in) |-> !measuring_flag_out
        && !hold_active_out && index_out == 8'h00) else $error("not idle after reset");
endmodule

bind smcr_regs smcr_regs_monitor mon (.clk_sys_in, .rst_in, .idx_wr_in, .data_wr_in,
    .data_rd_in, .wdata_in, .stop_in, .meas_state_in, .rdata_out, .index_out, .ready_pin_out,
    .ready_pin_oe_out, .measuring_flag_out, .hold_active_out, .core_tick_out);

// File: testbench/smcr_sync_src.sv
`timescale 1ns/10ps
module smcr_sync_src (
    // Pacing clock and burst control
    input  wire       clk_sys_in,
    input  wire       go_in,
    input  wire [7:0] edges_in,
    input  wire [7:0] half_in,
    // Sync line, idles high like a pulled-up pin
    output reg        sync_input_out
);
    integer n;
    initial sync_input_out = 1'b1;
    // A burst of low pulses; half_in sets prompt or slow spacing
    always @(posedge go_in) begin
        for (n = 0; n < edges_in; n = n + 1) begin
            repeat (half_in) @(negedge clk_sys_in);
            sync_input_out = 1'b0;
            repeat (half_in) @(negedge clk_sys_in);
            sync_input_out = 1'b1;
        end
    end
endmodule

// File: testbench/smcr_regs_tb.sv
`timescale 1ns/10ps
module smcr_regs_tb;
    // ----------------------------------------
    // Stimulus, observed outputs, bookkeeping
    // ----------------------------------------
    reg         clk_sys_in = 1'b0;
    reg         rst_in = 1'b1;
    reg         sw_reset_in = 1'b0;
    reg         idx_wr_in = 1'b0;
    reg         data_wr_in = 1'b0;
    reg         data_rd_in = 1'b0;
    reg  [7:0]  wdata_in = 8'h00;
    reg         stop_in = 1'b0;
    reg         meas_state_in = 1'b0;
    reg         cmd_start_in = 1'b0;
    reg  [23:0] conv_ticks_in = 24'h00_0001;
    reg         go = 1'b0;
    reg  [7:0]  n_edges = 8'h01;
    reg  [7:0]  half = 8'h08;
    wire        sync_input_in;
    wire [7:0]  rdata_out;
    wire [7:0]  index_out;
    wire        ready_pin_out;
    wire        ready_pin_oe_out;
    wire        measuring_flag_out;
    wire        hold_active_out;
    wire        core_tick_out;
    integer     error_cnt = 0;
    integer     n_checks = 0;
    integer     seed = 32'h1338_5dd1;
    integer     cyc = 0;
    integer     gap;
    integer     i;
    reg  [31:0] r;
    logic [7:0] exp_q[$]; // Expected read bytes, oldest first
    always #5 clk_sys_in = ~clk_sys_in;
    // Short pause step keeps free-running runs brief
    smcr_regs #(.PAUSE_STEP_CYC(18'd4)) uut (.clk_sys_in, .rst_in, .sw_reset_in, .idx_wr_in,
        .data_wr_in, .data_rd_in, .wdata_in, .stop_in, .meas_state_in, .rdata_out, .index_out,
        .cmd_start_in, .sync_input_in, .conv_ticks_in, .ready_pin_out, .ready_pin_oe_out,
        .measuring_flag_out, .hold_active_out, .core_tick_out);
    smcr_sync_src sync_src (.clk_sys_in, .go_in(go), .edges_in(n_edges), .half_in(half),
        .sync_input_out(sync_input_in));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task close_out;
        begin
            if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // One byte event; the idle cycle after it lets rdata settle
    task xfer(input [1:0] k, input [7:0] d);
        begin
            @(negedge clk_sys_in);
            {idx_wr_in, data_wr_in, data_rd_in, stop_in} = 4'h8 >> k;
            wdata_in = d;
            @(negedge clk_sys_in);
            {idx_wr_in, data_wr_in, data_rd_in, stop_in} = 4'h0;
            @(negedge clk_sys_in);
        end
    endtask
    task rd(input [7:0] e);
        begin
            exp_q.push_back(e);
            xfer(2'd2, 8'h00);
        end
    endtask
    task setreg(input [7:0] a, input [7:0] d);
        begin
            xfer(2'd0, a);
            xfer(2'd1, d);
        end
    endtask
    task wait_meas(input reg v, input integer lim);
        begin
            gap = 0;
            while (measuring_flag_out !== v && gap < lim) begin
                @(negedge clk_sys_in);
                gap = gap + 1;
            end
        end
    endtask
    task start_cmd;
        begin
            @(negedge clk_sys_in) cmd_start_in = 1'b1;
            @(negedge clk_sys_in) cmd_start_in = 1'b0;
        end
    endtask
    task read_defaults;
        begin
            xfer(2'd0, 8'h08);
            rd(8'h40);
            rd(8'h19);
            rd(8'h01);
            rd(8'h73);
        end
    endtask
    // Result watcher: each consumed byte is matched to its note
    always @(posedge clk_sys_in) begin
        if (data_rd_in && exp_q.size() > 0) check(rdata_out, exp_q.pop_front());
    end
    // Hang guard
    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys_in);
        @(negedge clk_sys_in) rst_in = 1'b0;
        read_defaults;
        r = $random(seed);
        setreg(8'h08, {2'b01, r[5], 1'b0, r[3:0]});
        xfer(2'd1, r[15:8]);
        xfer(2'd1, 8'h00);
        xfer(2'd1, 8'h00);
        xfer(2'd0, 8'h08);
        rd({4'h4, r[3], 1'b0, r[1:0]});
        rd(r[15:8]);
        rd(8'h01);
        rd(8'h00);
        rd(8'h00);
        xfer(2'd3, 8'h00);
        check(index_out, 8'h0D);
        setreg(8'h0B, 8'h01);
        meas_state_in = 1'b1;
        xfer(2'd3, 8'h00);
        check(index_out, 8'h02);
        meas_state_in = 1'b0;
        xfer(2'd3, 8'h00);
        check(index_out, 8'h00);
        // Command mode, push-pull then open-drain pin
        setreg(8'h08, 8'h43);
        check({6'h00, ready_pin_oe_out, ready_pin_out}, 8'h03);
        start_cmd;
        check({measuring_flag_out, 5'h00, ready_pin_oe_out, ready_pin_out}, 8'h82);
        wait_meas(1'b0, 40);
        wait_meas(1'b1, 100);
        check({7'h00, measuring_flag_out}, 8'h00);
        setreg(8'h08, 8'h4B);
        check({6'h00, ready_pin_oe_out, ready_pin_out}, 8'h00);
        start_cmd;
        check({measuring_flag_out, 5'h00, ready_pin_oe_out, ready_pin_out}, 8'h82);
        wait_meas(1'b0, 40);
        // Free running with pause 5 and then 0
        setreg(8'h09, 8'h05);
        setreg(8'h08, 8'h03);
        wait_meas(1'b1, 60);
        wait_meas(1'b0, 40);
        wait_meas(1'b1, 60);
        check({7'h00, gap >= 19 && gap <= 23}, 8'h01);
        setreg(8'h09, 8'h00);
        wait_meas(1'b0, 60);
        wait_meas(1'b1, 60);
        wait_meas(1'b0, 40);
        wait_meas(1'b1, 80);
        check({7'h00, gap >= 36 && gap <= 40}, 8'h01);
        // Hold aborts, then wake-up bound
        setreg(8'h08, 8'h13);
        repeat (5) @(negedge clk_sys_in);
        check({6'h00, hold_active_out, measuring_flag_out}, 8'h02);
        setreg(8'h08, 8'h03);
        wait_meas(1'b1, 500);
        check({7'h00, gap >= 395 && gap <= 410}, 8'h01);
        // Start on sync only
        setreg(8'h09, 8'h01);
        setreg(8'h08, 8'h83);
        wait_meas(1'b0, 100);
        repeat (40) @(negedge clk_sys_in);
        check({7'h00, measuring_flag_out}, 8'h00);
        go = 1'b1;
        wait_meas(1'b1, 40);
        go = 1'b0;
        check({7'h00, measuring_flag_out}, 8'h01);
        wait_meas(1'b0, 40);
        wait_meas(1'b1, 80);
        check({7'h00, measuring_flag_out}, 8'h00);
        // Start and end on sync, two further edges
        setreg(8'h0A, 8'h02);
        conv_ticks_in = 24'hFF_FFFF;
        setreg(8'h08, 8'hC3);
        {n_edges, half, go} = {8'h03, 8'h14, 1'b1};
        wait_meas(1'b1, 60);
        go = 1'b0;
        repeat (60) @(negedge clk_sys_in);
        check({7'h00, measuring_flag_out}, 8'h01);
        wait_meas(1'b0, 40);
        check({7'h00, measuring_flag_out}, 8'h00);
        conv_ticks_in = 24'h00_0001;
        // Core tick rate for each select code
        for (i = 0; i < 4; i = i + 1) begin
            setreg(8'h08, {6'h10, i[1:0]});
            gap = 0;
            repeat (2000) @(negedge clk_sys_in) gap = gap + core_tick_out;
            check({7'h00, gap >= (2048 << i) / 100 - 1 && gap <= (2048 << i) / 100 + 2},
                8'h01);
        end
        @(negedge clk_sys_in) sw_reset_in = 1'b1;
        @(negedge clk_sys_in) sw_reset_in = 1'b0;
        read_defaults;
        close_out;
    end
endmodule
